// ### design/cct_pkg.sv
// Constants and types shared by the capture/compare timer files.
// Assumes a 32-bit Wishbone slave with word-aligned 16-bit registers.
package cct_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00; // Timer control register
  localparam logic [7:0] OFS_IOC  = 8'h04; // I/O control setting
  localparam logic [7:0] OFS_STAT = 8'h08; // Match and overflow flags
  localparam logic [7:0] OFS_IEN  = 8'h0C; // Interrupt enables
  localparam logic [7:0] OFS_CNT  = 8'h10; // Main count
  localparam logic [7:0] OFS_REG_A = 8'h14; // General register a
  localparam logic [7:0] OFS_REG_B = 8'h18; // General register b
  localparam logic [7:0] OFS_REG_C = 8'h1C; // General register c
  localparam logic [7:0] OFS_REG_D = 8'h20; // General register d

  // Control register field positions
  localparam int CTL_RUN  = 0;  // Counter runs
  localparam int CTL_CLR  = 1;  // Clear on match a
  localparam int CTL_CKS  = 2;  // Clock select, three bits
  localparam int CTL_LVL  = 8;  // Initial levels a..d, four bits
  localparam int CTL_BUFA = 12; // Register c buffers register a
  localparam int CTL_BUFB = 13; // Register d buffers register b
  localparam int CTL_STBY = 15; // Module standby

  // I/O control nibble per channel: [3] capture, [1:0] edge or action
  localparam int IOC_CAP  = 3;

  // Status bit of the overflow flag, match flags sit in bits 3..0
  localparam int STAT_WRAP = 4;

  // Reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] IOC_RST  = 16'h0000;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [15:0] REG_RST  = 16'hFFFF;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;

  // Clock select code for the external count clock
  localparam logic [2:0] CKS_EXT = 3'h4;

  // Capture edge codes; 1X means both edges
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;

  // Compare output actions
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW  = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOG  = 2'h3;

  // Bus handshake states
  typedef enum logic {BUS_IDLE, BUS_DONE} cct_bus_t;
endpackage : cct_pkg

// ### design/cct_edge.sv
// Input synchroniser with rising and falling edge detection.
// Assumes the input is a slow pin level, held two clocks or more.
`timescale 1ns/1ns
module cct_edge (
  input  wire logic clk_i,  // System clock
  input  wire logic rst_i,  // Synchronous reset, active high
  input  wire logic sig_i,  // Raw pin level
  output logic      rise_o, // One-cycle pulse on a rising edge
  output logic      fall_o  // One-cycle pulse on a falling edge
);
  logic [2:0] smp_ff;     // Sync stages plus previous sample
  logic [2:0] nxt_smp;    // Next sample chain

  // Shift chain; only stage 1 reads stage 0
  always_comb
  begin
    nxt_smp = {smp_ff[1:0], sig_i};
  end

  // Register the chain
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      smp_ff <= 3'h0;
    else
      smp_ff <= nxt_smp;
  end

  // Compare successive synchronised samples [R21]
  assign rise_o = smp_ff[1] & ~smp_ff[2];
  assign fall_o = ~smp_ff[1] & smp_ff[2];

  // A level held two clocks gives an edge within three clocks
  chk_edge_seen: assert property (@(posedge clk_i) disable iff (rst_i) // [R21]
    (!sig_i ##1 sig_i [*2]) |-> ##[1:3] rise_o)
    else $error("held rising level not detected");
endmodule : cct_edge

// ### design/cct_prescale.sv
// Count clock source: divided system clock or external clock edge.
// Assumes the external edge pulse comes from a synchronised pin.
`timescale 1ns/1ns
module cct_prescale (
  input  wire logic       clk_i,      // System clock
  input  wire logic       rst_i,      // Synchronous reset, active high
  input  wire logic [2:0] sel_i,      // Clock select
  input  wire logic       ext_rise_i, // External clock rising edge
  output logic            tick_o      // One-cycle count pulse
);
  logic [3:0] div_ff;     // Free-running divider
  logic [3:0] nxt_div;    // Next divider value
  logic       prev_ff;    // Previous selected divided level
  logic       nxt_prev;   // Next previous level
  logic       lvl;        // Selected divided level

  // Select one divider bit; codes 0..3 divide by 2, 4, 8, 16
  assign lvl = div_ff[sel_i[1:0]];

  // Next divider and level history
  always_comb
  begin
    nxt_div  = div_ff + 4'h1;
    nxt_prev = lvl;
  end

  // Register divider and history
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_ff  <= 4'h0;
      prev_ff <= 1'b0;
    end
    else
    begin
      div_ff  <= nxt_div;
      prev_ff <= nxt_prev;
    end
  end

  // Pulse on a rising selected level; a switch low to high also counts
  assign tick_o = (sel_i >= cct_pkg::CKS_EXT) ? ext_rise_i // [R12]
                                              : (lvl & ~prev_ff);

  // An internal tick always follows a low selected level
  chk_tick_rise: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
    (tick_o && sel_i < cct_pkg::CKS_EXT) |-> !prev_ff && lvl)
    else $error("internal tick without rising level");
endmodule : cct_prescale

// ### design/cct_timer.sv
// 16-bit capture/compare timer with four general registers.
// Assumes a classic Wishbone master and pins synchronous to clk_i.
// Summary of operation
// R01: External count clock holds levels two cycles
// R02: Match event fires as count leaves value
// R03: Match drives pin with configured action
// R04: Capture on rising, falling or both edges
// R05: Capture input holds levels two cycles
// R06: Clear on match a gives N+1 period
// R07: Compare match sets its match flag
// R08: Capture sets match flag when value stored
// R09: Flag clears on read-one then write-zero
// R10: Counter clear beats a counter write
// R11: Counter write beats a count increment
// R12: Increment on rising divided clock level
// R13: Standby keeps pending interrupt request asserted
// R14: Initial levels set pins until match
// R15: Control write beats coinciding match pin change
// R16: Software stops counter before control rewrite
// R17: Edge codes 00 rise, 01 fall, 1X both
// R18: Wrap to zero sets overflow flag
// R19: Match sets pin low, high or toggles
// R20: Buffer c loads register a on match
// R21: Inputs synchronised, edges from successive samples
`timescale 1ns/1ns
module cct_timer (
  input  wire logic        clk_i,               // System clock
  input  wire logic        rst_i,               // Sync reset, high
  input  wire logic        wb_cyc_i,            // Bus cycle
  input  wire logic        wb_stb_i,            // Bus strobe
  input  wire logic        wb_we_i,             // Write enable
  input  wire logic [7:0]  wb_adr_i,            // Byte address
  input  wire logic [3:0]  wb_sel_i,            // Byte lanes
  input  wire logic [31:0] wb_dat_i,            // Write data
  output logic      [31:0] wb_dat_o,            // Read data
  output logic             wb_ack_o,            // Acknowledge
  input  wire logic        ext_clk_i,           // External count clock
  input  wire logic [3:0]  timer_pin_i,         // Pin levels a..d
  output logic      [3:0]  timer_pin_o,         // Pin drive a..d
  output logic      [3:0]  timer_pin_oe_o,      // Pin drive enable
  output logic             timer_irq_request_o  // Interrupt request
);
  cct_pkg::cct_bus_t bus_ff;       // Bus handshake state
  cct_pkg::cct_bus_t nxt_bus;      // Next handshake state
  logic [31:0]       dat_ff;       // Registered read data
  logic [31:0]       nxt_dat;      // Next read data
  logic [15:0]       ctrl_ff;      // Timer control register
  logic [15:0]       nxt_ctrl;
  logic [15:0]       ioc_ff;       // I/O control setting
  logic [15:0]       nxt_ioc;
  logic [4:0]        ien_ff;       // Interrupt enables
  logic [4:0]        nxt_ien;
  logic [4:0]        stat_ff;      // Match flags and overflow flag
  logic [4:0]        nxt_stat;
  logic [4:0]        seen_ff;      // Flags read while set
  logic [4:0]        nxt_seen;
  logic [15:0]       main_count_ff; // Main count
  logic [15:0]       nxt_count;
  logic [15:0]       general_reg_ff [4]; // General registers a..d
  logic [15:0]       nxt_general_reg [4];
  logic [3:0]        pin_ff;       // Pin levels
  logic [3:0]        nxt_pin;
  logic [3:0]        oe_ff;        // Pin drive enables
  logic              irq_ff;       // Interrupt request
  logic              nxt_irq;
  logic              take;         // Request taken this cycle
  logic              wr_ok;        // Write with both low lanes
  logic              wr_ctrl;      // Control write
  logic              wr_stat;      // Status write
  logic              rd_stat;      // Status read
  logic              wr_cnt;       // Count write
  logic              stby;         // Module standby
  logic              tick;         // Count pulse
  logic              tick_ok;      // Count pulse while running
  logic              clr_ev;       // Clear on match a
  logic              wrap_ev;      // Count wraps to zero
  logic              ext_rise;     // External clock rising edge
  logic [3:0]        is_cap;       // Channel in capture mode
  logic [3:0]        match_ev;     // Compare match events
  logic [3:0]        capt_ev;      // Capture events
  logic [3:0]        pin_rise;     // Capture pin rising edges
  logic [3:0]        pin_fall;     // Capture pin falling edges
  logic [15:0]       wdat;         // Low half of write data

  // Bus decode; standby blocks every register write except control
  assign take    = wb_cyc_i & wb_stb_i & (bus_ff == cct_pkg::BUS_IDLE);
  assign wr_ok   = take & wb_we_i & (wb_sel_i[1:0] == 2'h3);
  assign wr_ctrl = wr_ok & (wb_adr_i == cct_pkg::OFS_CTRL);
  assign wr_stat = wr_ok & ~stby & (wb_adr_i == cct_pkg::OFS_STAT);
  assign rd_stat = take & ~wb_we_i & (wb_adr_i == cct_pkg::OFS_STAT);
  assign wr_cnt  = wr_ok & ~stby & (wb_adr_i == cct_pkg::OFS_CNT);
  assign wdat    = wb_dat_i[15:0];
  assign stby    = ctrl_ff[cct_pkg::CTL_STBY];

  // External count clock is synchronised like any pin [R01]
  cct_edge u_ext_edge (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .sig_i  (ext_clk_i),
    .rise_o (ext_rise),
    .fall_o ()
  );

  // Count pulse source
  cct_prescale u_prescale (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .sel_i      (ctrl_ff[cct_pkg::CTL_CKS +: 3]),
    .ext_rise_i (ext_rise),
    .tick_o     (tick)
  );
  // Counter advances only while running and awake
  assign tick_ok = tick & ctrl_ff[cct_pkg::CTL_RUN] & ~stby;

  // Per-channel edge detection and event generation
  genvar g;
  for (g = 0; g < 4; g++)
  begin : g_ch
    logic [1:0] md;  // Edge or action code of this channel
    assign md = ioc_ff[4*g +: 2];
    assign is_cap[g] = ioc_ff[4*g + cct_pkg::IOC_CAP];
    // Capture pins need two-cycle levels [R05]
    cct_edge u_pin_edge (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .sig_i  (timer_pin_i[g]),
      .rise_o (pin_rise[g]),
      .fall_o (pin_fall[g])
    );
    // Match in the last state of equality, as the count moves on [R02]
    assign match_ev[g] = tick_ok & ~is_cap[g] &
                         (main_count_ff == general_reg_ff[g]);
    // Edge select: 00 rising, 01 falling, 1X both [R04] [R17]
    assign capt_ev[g] = ~stby & is_cap[g] &
                        (md[1] ? (pin_rise[g] | pin_fall[g]) :
                         (md == cct_pkg::EDGE_FALL) ? pin_fall[g] :
                         pin_rise[g]);
  end
  // Clear on match a and wrap events; a count write drops the wrap [R11]
  assign clr_ev  = match_ev[0] & ctrl_ff[cct_pkg::CTL_CLR] & ~is_cap[0];
  assign wrap_ev = tick_ok & ~clr_ev & ~wr_cnt &
                   (main_count_ff == cct_pkg::CNT_MAX);
  // Bus handshake and read data
  always_comb
  begin
    nxt_bus = cct_pkg::BUS_IDLE;
    nxt_dat = dat_ff;
    if (take)
    begin
      nxt_bus = cct_pkg::BUS_DONE;
      case (wb_adr_i)
        cct_pkg::OFS_CTRL: nxt_dat = {16'h0000, ctrl_ff};
        cct_pkg::OFS_IOC:  nxt_dat = {16'h0000, ioc_ff};
        cct_pkg::OFS_STAT: nxt_dat = {27'h0000000, stat_ff};
        cct_pkg::OFS_IEN:  nxt_dat = {27'h0000000, ien_ff};
        cct_pkg::OFS_CNT:  nxt_dat = {16'h0000, main_count_ff};
        cct_pkg::OFS_REG_A: nxt_dat = {16'h0000, general_reg_ff[0]};
        cct_pkg::OFS_REG_B: nxt_dat = {16'h0000, general_reg_ff[1]};
        cct_pkg::OFS_REG_C: nxt_dat = {16'h0000, general_reg_ff[2]};
        cct_pkg::OFS_REG_D: nxt_dat = {16'h0000, general_reg_ff[3]};
        default:           nxt_dat = 32'h00000000; // Unmapped reads zero
      endcase
    end
  end

  // Configuration registers; control stays writable in standby
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_ioc  = ioc_ff;
    nxt_ien  = ien_ff;
    if (wr_ctrl)
      nxt_ctrl = wdat;
    if (wr_ok & ~stby & (wb_adr_i == cct_pkg::OFS_IOC))
      nxt_ioc = wdat;
    if (wr_ok & ~stby & (wb_adr_i == cct_pkg::OFS_IEN))
      nxt_ien = wdat[4:0];
  end

  // Main count: clear beats write, write beats increment
  always_comb
  begin
    nxt_count = main_count_ff;
    if (clr_ev)
      nxt_count = cct_pkg::CNT_RST;         // Period of N + 1 [R06] [R10]
    else if (wr_cnt)
      nxt_count = wdat;                     // Increment dropped [R11]
    else if (tick_ok)
      nxt_count = main_count_ff + 16'h0001; // Wraps at the top [R18]
  end

  // General registers: bus write, then capture, then buffer moves
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      nxt_general_reg[i] = general_reg_ff[i];
      if (wr_ok & ~stby & (wb_adr_i == cct_pkg::OFS_REG_A + 8'(4*i)))
        nxt_general_reg[i] = wdat;
      if (capt_ev[i])
        nxt_general_reg[i] = main_count_ff; // Capture the count [R08]
    end
    // Buffer register c feeds register a on match a [R20]
    if (ctrl_ff[cct_pkg::CTL_BUFA] & match_ev[0])
      nxt_general_reg[0] = general_reg_ff[2];
    if (ctrl_ff[cct_pkg::CTL_BUFB] & match_ev[1])
      nxt_general_reg[1] = general_reg_ff[3];
    // On capture the old value moves into the buffer
    if (ctrl_ff[cct_pkg::CTL_BUFA] & capt_ev[0])
      nxt_general_reg[2] = general_reg_ff[0];
    if (ctrl_ff[cct_pkg::CTL_BUFB] & capt_ev[1])
      nxt_general_reg[3] = general_reg_ff[1];
  end

  // Flags: cleared by read-one then write-zero, a new event wins
  always_comb
  begin
    nxt_stat = stat_ff;
    nxt_seen = seen_ff;
    if (rd_stat)
      nxt_seen = seen_ff | stat_ff;         // Remember bits read as one
    if (wr_stat)
    begin
      nxt_stat = stat_ff & ~(seen_ff & ~wdat[4:0]); // [R09]
      nxt_seen = 5'h00;
    end
    nxt_stat[3:0] = nxt_stat[3:0] | match_ev | capt_ev; // [R07] [R08]
    nxt_stat[cct_pkg::STAT_WRAP] = nxt_stat[cct_pkg::STAT_WRAP] | wrap_ev;
    // Request follows flags, which standby freezes [R13]
    nxt_irq = |(stat_ff & ien_ff);
  end

  // Pins: control write loads initial levels and beats a match
  always_comb
  begin
    nxt_pin = pin_ff;
    if (wr_ctrl)
      nxt_pin = wdat[cct_pkg::CTL_LVL +: 4]; // [R14] [R15]
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (match_ev[i])                     // Action on match [R03]
        begin
          case (ioc_ff[4*i +: 2])
            cct_pkg::ACT_LOW:  nxt_pin[i] = 1'b0; // [R19]
            cct_pkg::ACT_HIGH: nxt_pin[i] = 1'b1;
            cct_pkg::ACT_TOG:  nxt_pin[i] = ~pin_ff[i];
            default:           nxt_pin[i] = pin_ff[i];
          endcase
        end
      end
    end
  end

  // Register every group of state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_ff        <= cct_pkg::BUS_IDLE;
      dat_ff        <= 32'h00000000;
      ctrl_ff       <= cct_pkg::CTRL_RST;
      ioc_ff        <= cct_pkg::IOC_RST;
      ien_ff        <= 5'h00;
      stat_ff       <= 5'h00;
      seen_ff       <= 5'h00;
      main_count_ff <= cct_pkg::CNT_RST;
      for (int i = 0; i < 4; i++)
        general_reg_ff[i] <= cct_pkg::REG_RST;
      pin_ff        <= 4'h0;
      oe_ff         <= 4'h0;
      irq_ff        <= 1'b0;
    end
    else
    begin
      bus_ff        <= nxt_bus;
      dat_ff        <= nxt_dat;
      ctrl_ff       <= nxt_ctrl;
      ioc_ff        <= nxt_ioc;
      ien_ff        <= nxt_ien;
      stat_ff       <= nxt_stat;
      seen_ff       <= nxt_seen;
      main_count_ff <= nxt_count;
      general_reg_ff <= nxt_general_reg;
      pin_ff        <= nxt_pin;
      oe_ff         <= ~is_cap;
      irq_ff        <= nxt_irq;
    end
  end

  // Outputs straight from flip-flops
  assign wb_dat_o            = dat_ff;
  assign wb_ack_o            = (bus_ff == cct_pkg::BUS_DONE);
  assign timer_pin_o         = pin_ff;
  assign timer_pin_oe_o      = oe_ff;
  assign timer_irq_request_o = irq_ff;

  // Match on a with no control write in the same cycle
  sequence s_hit_a;
    match_ev[0] && !wr_ctrl;
  endsequence
  // Toggle action on channel a without a competing control write
  sequence s_tog_a;
    match_ev[0] && !wr_ctrl && ioc_ff[1:0] == cct_pkg::ACT_TOG;
  endsequence
  chk_match_flag: assert property (@(posedge clk_i) disable iff (rst_i) // [R07]
    s_hit_a |=> stat_ff[0])
    else $error("match flag a not set");
  chk_clear_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [R06]
    clr_ev |=> main_count_ff == 16'h0000 && stat_ff[0])
    else $error("count not cleared on match a");
  chk_clear_wins: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
    (wr_cnt && clr_ev) |=> main_count_ff == 16'h0000)
    else $error("count write beat clear");
  chk_write_wins: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    (wr_cnt && !clr_ev) |=> main_count_ff == $past(wb_dat_i[15:0]))
    else $error("count write lost");
  chk_wrap_flag: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
    wrap_ev |=> main_count_ff == 16'h0000 && stat_ff[cct_pkg::STAT_WRAP])
    else $error("overflow not flagged");
  chk_pin_toggle: assert property (@(posedge clk_i) disable iff (rst_i) // [R19]
    s_tog_a |=> timer_pin_o[0] != $past(timer_pin_o[0]))
    else $error("pin a did not toggle");
  chk_ctrl_prio: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
    wr_ctrl |=> timer_pin_o == $past(wb_dat_i[11:8]))
    else $error("pins differ from written levels");
  chk_flag_keep: assert property (@(posedge clk_i) disable iff (rst_i) // [R09]
    (wr_stat && !wb_dat_i[0] && !seen_ff[0] && stat_ff[0]) |=> stat_ff[0])
    else $error("flag cleared without prior read");
  chk_capture_b: assert property (@(posedge clk_i) disable iff (rst_i) // [R08]
    capt_ev[1] |=> general_reg_ff[1] == $past(main_count_ff) && stat_ff[1])
    else $error("capture b not stored");
  chk_stby_irq: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
    (stby && $past(stby) && irq_ff) |=> irq_ff [*2])
    else $error("request dropped in standby");
endmodule : cct_timer

// ### verif/cct_far_side.sv
// Model of the pins around the timer: count clock and capture inputs.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ns
module cct_far_side (
  input  wire logic       clk_i,     // System clock
  output logic            ext_clk_o, // External count clock
  output logic      [3:0] pin_o      // Capture pin levels a..d
);
  // Both lines rest low outside driven events
  initial
  begin
    ext_clk_o = 1'b0;
    pin_o     = 4'h0;
  end

  // New pin level, held three clocks before anything else moves
  task automatic set_pin(input int idx, input logic v);
    @(posedge clk_i);
    pin_o[idx] <= v;
    repeat (3) @(posedge clk_i);
  endtask : set_pin

  // One count clock pulse, two clocks high and two low
  task automatic ext_pulse();
    @(posedge clk_i);
    ext_clk_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    ext_clk_o <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : ext_pulse
endmodule : cct_far_side

// ### verif/cct_timer_bench.sv
// Self-checking bench for the capture/compare timer.
// Assumes the register map and timing of the package constants.
`timescale 1ns/1ns
module cct_timer_bench;
  logic        clk_i;       // System clock
  logic        rst_i;       // Synchronous reset
  logic        wb_cyc;      // Bus cycle
  logic        wb_stb;      // Bus strobe
  logic        wb_we;       // Write enable
  logic [7:0]  wb_adr;      // Byte address
  logic [3:0]  wb_sel;      // Byte lanes
  logic [31:0] wb_dat;      // Write data
  logic [31:0] wb_dat_o;    // Read data
  logic        wb_ack_o;    // Acknowledge
  logic        ext_clk;     // Count clock from the model
  logic [3:0]  far_pin;     // Capture levels from the model
  logic [3:0]  pin_w;       // Resolved pin levels
  logic [3:0]  pin_o;       // Timer pin drive
  logic [3:0]  pin_oe;      // Timer pin enable
  logic        irq;         // Interrupt request
  logic [31:0] exp_q[$];    // Expected read data, oldest first
  int          n_fail;      // Mismatches
  int          checks_done; // Comparisons
  int          cycles;      // Timeout counter
  int          t;           // Measured cycles
  integer      seed;        // Random seed
  logic [15:0] n;           // Compare value a
  logic [15:0] v;           // Captured count value

  // Pin level: timer drives where enabled, model elsewhere
  assign pin_w = (pin_oe & pin_o) | (~pin_oe & far_pin);

  cct_timer u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ext_clk_i(ext_clk), .timer_pin_i(pin_w), .timer_pin_o(pin_o),
    .timer_pin_oe_o(pin_oe), .timer_irq_request_o(irq));

  cct_far_side u_far (.clk_i(clk_i), .ext_clk_o(ext_clk), .pin_o(far_pin));

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  // Compare one value and count it
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Print counts and verdict, then end the run
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  // Classic single Wishbone cycle, held until ack is sampled
  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [15:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_dat <= {16'h0000, d};
    wb_sel <= 4'hF;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : bus

  // Register write
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask : wr

  // Register read; the expected word goes to the queue
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 16'h0000);
  endtask : rd

  // Cycles until pin a changes level
  task automatic wait_pin(output int cnt);
    logic p;
    cnt = 0;
    p = pin_o[0];
    while (pin_o[0] === p && cnt < 500)
    begin
      @(posedge clk_i);
      cnt++;
    end
  endtask : wait_pin

  // Ends one test with a line
  task automatic tdone(input string s);
    $display("Test done: %s", s);
  endtask : tdone

  // Read watcher: each read ack takes the oldest expectation
  always @(posedge clk_i)
  begin
    if (wb_ack_o === 1'b1 && wb_we === 1'b0 && exp_q.size() > 0)
      check(wb_dat_o, exp_q.pop_front());
  end

  // Hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_fail++;
      stop_test();
    end
  end

  // Main sequence
  initial
  begin
    clk_i = 1'b0; rst_i = 1'b1; wb_cyc = 1'b0; wb_stb = 1'b0;
    wb_we = 1'b0; wb_adr = 8'h00; wb_sel = 4'h0; wb_dat = 32'h0;
    n_fail = 0; checks_done = 0; cycles = 0; seed = 32'hA2FD40A7;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values and an unmapped place
    rd(cct_pkg::OFS_CNT, 32'h0000_0000);
    rd(cct_pkg::OFS_REG_A, 32'h0000_FFFF);
    rd(cct_pkg::OFS_CTRL, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    tdone("reset");
    // Initial levels reach the pins
    wr(cct_pkg::OFS_CTRL, 16'h0A00);
    @(negedge clk_i);
    check({28'h0, pin_o}, 32'h0000_000A);
    wr(cct_pkg::OFS_CTRL, 16'h0000);
    tdone("levels");
    // Toggle on match a with clear: period 2*(N+1) clocks at clk/2
    n = 16'h0003 + {13'h0, 3'($random(seed))};
    wr(cct_pkg::OFS_REG_A, n);
    wr(cct_pkg::OFS_IOC, 16'h0003);
    wr(cct_pkg::OFS_CTRL, 16'h0003);
    wait_pin(t);
    wait_pin(t);
    check(32'(t), 32'(n) * 2 + 32'h2);
    wait_pin(t);
    check(32'(t), 32'(n) * 2 + 32'h2);
    // Stop first, copying pin a (high after three toggles) into its level
    wr(cct_pkg::OFS_CTRL, 16'h0100);
    check({28'h0, pin_o}, 32'h0000_0001);
    check({28'h0, pin_oe}, 32'h0000_000F);
    wr(cct_pkg::OFS_STAT, 16'h0000);
    rd(cct_pkg::OFS_STAT, 32'h0000_0001);
    wr(cct_pkg::OFS_STAT, 16'h0000);
    rd(cct_pkg::OFS_STAT, 32'h0000_0000);
    tdone("compare");
    // Capture on b with every edge code
    v = 16'($random(seed));
    wr(cct_pkg::OFS_CNT, v);
    for (int c = 0; c < 4; c++)
    begin
      wr(cct_pkg::OFS_IOC, {8'h00, 4'h8 | 4'(c), 4'h0});
      u_far.set_pin(1, 1'b1);
      rd(cct_pkg::OFS_STAT, (c != 1) ? 32'h2 : 32'h0);
      wr(cct_pkg::OFS_STAT, 16'h0000);
      u_far.set_pin(1, 1'b0);
      rd(cct_pkg::OFS_STAT, (c != 0) ? 32'h2 : 32'h0);
      wr(cct_pkg::OFS_STAT, 16'h0000);
    end
    rd(cct_pkg::OFS_REG_B, {16'h0000, v});
    tdone("capture");
    // Count write meets a count-up, then a clear, at the same edge
    wr(cct_pkg::OFS_IOC, 16'h0000);
    wr(cct_pkg::OFS_REG_A, 16'h0007);
    wr(cct_pkg::OFS_CTRL, 16'h0013);
    for (int k = 0; k < 2; k++)
    begin
      wr(cct_pkg::OFS_CNT, 16'h0006 + 16'(k));
      // Synced edge ticks three clocks after the pin; the write meets it
      fork
        u_far.ext_pulse();
        begin
          repeat (2) @(posedge clk_i);
          wr(cct_pkg::OFS_CNT, 16'h1234);
        end
      join
      rd(cct_pkg::OFS_CNT, (k == 0) ? 32'h1234 : 32'h0);
    end
    rd(cct_pkg::OFS_STAT, 32'h0000_0001);
    wr(cct_pkg::OFS_STAT, 16'h0000);
    tdone("write contention");
    // External count clock, five pulses
    wr(cct_pkg::OFS_IOC, 16'h8888);
    wr(cct_pkg::OFS_CNT, 16'h0000);
    wr(cct_pkg::OFS_CTRL, 16'h0011);
    repeat (5) u_far.ext_pulse();
    repeat (4) @(posedge clk_i);
    wr(cct_pkg::OFS_CTRL, 16'h0000);
    rd(cct_pkg::OFS_CNT, 32'h0000_0005);
    tdone("external clock");
    // Overflow, interrupt, then standby keeps the request
    wr(cct_pkg::OFS_CNT, 16'hFFFF);
    wr(cct_pkg::OFS_IEN, 16'h0010);
    wr(cct_pkg::OFS_CTRL, 16'h0001);
    repeat (8) @(posedge clk_i);
    wr(cct_pkg::OFS_CTRL, 16'h8000);
    rd(cct_pkg::OFS_STAT, 32'h0000_0010);
    wr(cct_pkg::OFS_STAT, 16'h0000);
    repeat (2) @(negedge clk_i);
    check({31'h0, irq}, 32'h0000_0001);
    tdone("overflow and standby");
    repeat (3) @(posedge clk_i);
    stop_test();
  end
endmodule : cct_timer_bench
